// ---- verilog/twdl_defines.vh ----
// Constants for the trigger word, delay and difference counter logic
`ifndef TWDL_DEFINES_VH
`define TWDL_DEFINES_VH
`define TWDL_WORD_BITS      4
`define TWDL_EXP_INPUTS     4
`define TWDL_LOWER_BITS     4
`define TWDL_UPPER_BITS     12
`define TWDL_DIV_PRESET     2'b11
`define TWDL_DIFF_BITS      16
`define TWDL_DIFF_MAX       16'h7fff
`define TWDL_HALT_CLOCKS    3
`define TWDL_HALT_CNT_BITS  2
`define TWDL_LOWER_TERMINAL 4'hf
`endif

// ---- verilog/twdl_sync2.v ----
// Two-flip-flop synchroniser for a bus of levels
`timescale 1ns/10ps
module twdl_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta   <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule

// ---- verilog/twdl_word_match.v ----
// Four-bit word recognizer: polarity, care mask, registered match bits
`timescale 1ns/10ps
`include "twdl_defines.vh"
module twdl_word_match (
    input  wire                       clk_i,
    input  wire                       rst_n_i,
    input  wire [`TWDL_WORD_BITS-1:0] data_i,
    input  wire [`TWDL_WORD_BITS-1:0] polarity_i,
    input  wire [`TWDL_WORD_BITS-1:0] dont_care_i,
    input  wire                       extra_match_n_i,
    output wire                       recognized_n_o
);
    reg [`TWDL_WORD_BITS-1:0] match_n;

    genvar b;
    generate
        for (b = 0; b < `TWDL_WORD_BITS; b = b + 1) begin : g_bit
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    match_n[b] <= 1'b0;
                end else if (dont_care_i[b]) begin
                    match_n[b] <= 1'b0;
                end else begin
                    match_n[b] <= data_i[b] ^ polarity_i[b];
                end
            end
        end
    endgenerate

    // Low only when all four bit matches and the fifth input are low
    assign recognized_n_o = |{match_n, extra_match_n_i};
endmodule

// ---- verilog/twdl_trigger_delay.v ----
// Trigger latch, post-trigger delay counter and difference counter
//
// Behaviour
// - Each data bit passes a polarity inverter; match is active low.
// - Don't-care bits hold their match register low; others register the inverter.
// - Recognition is low only when four bit matches and fifth input are low.
// - Recognition is latched and forwarded on the next phase C edge.
// - Own recognition NORed with all expander recognitions; absent inputs held low.
// - Trigger latch captures high on phase D and holds until cleared.
// - Arm inhibit masks the trigger latch; slow-arms mode inhibits until slow trigger.
// - Delay counter runs at quarter rate, divider starts after trigger.
// - Both divider registers preset while delay load is asserted.
// - Lower section loads four bits from load bus while load enable high.
// - Lower section increments per quarter-rate edge, none before trigger.
// - Lower section msb clocks the upper section, forming one counter.
// - Upper carry plus lower terminal count asserts halt, freezing the counter.
// - Acquisition stops exactly three clocks after the halt request.
// - Delay counter spans more than 32,700 clock cycles.
// - Trigger clear zeroes the difference counter.
// - Difference counter counts on slow clock while slow triggered, fast not.
// - Fast trigger drops the count enable and the count holds.
// - Difference counter stops at 7fff rather than wrapping.
// - Counter stays zero unless slow module triggers first.
// - Two active-low byte enables put one count byte each on the bus.
`timescale 1ns/10ps
`include "twdl_defines.vh"
module twdl_trigger_delay (
    input  wire                        clk_i,
    input  wire                        rst_n_i,
    input  wire                        phase_c_i,
    input  wire                        phase_d_i,
    input  wire [`TWDL_WORD_BITS-1:0]  data_i,
    input  wire [`TWDL_WORD_BITS-1:0]  bit_polarity_select_i,
    input  wire [`TWDL_WORD_BITS-1:0]  bit_dont_care_i,
    input  wire [`TWDL_EXP_INPUTS-1:0] expander_recognized_n_i,
    input  wire                        arm_inhibit_i,
    input  wire                        slow_arms_fast_mode_i,
    input  wire                        trigger_clear_i,
    input  wire                        delay_load_enable_i,
    input  wire [`TWDL_LOWER_BITS-1:0] delay_load_nibble_bus_i,
    input  wire [`TWDL_UPPER_BITS-1:0] delay_load_upper_i,
    input  wire                        slow_module_triggered_i,
    input  wire                        slow_module_clock_i,
    input  wire                        diff_low_byte_enable_n_i,
    input  wire                        diff_high_byte_enable_n_i,
    output reg                         triggered_o,
    output reg                         fast_module_triggered_n_o,
    output reg                         acquisition_halt_request_o,
    output reg                         acquisition_running_o,
    output reg  [7:0]                  bus_data_o,
    output reg                         bus_data_oe_o,
    output reg  [`TWDL_DIFF_BITS-1:0]  diff_count_o
);
    // All inputs except polarity, don't care, mode select and the delay load buses pass two flip-flops before use.
    // Read enables cross inverted so the synchroniser's reset level means idle,
    // otherwise the bus would be driven for two clocks after reset.
    localparam SYNC_W = `TWDL_WORD_BITS + `TWDL_EXP_INPUTS + 9;

    wire [SYNC_W-1:0] sync_in;
    wire [`TWDL_WORD_BITS-1:0]  data_s;
    wire [`TWDL_EXP_INPUTS-1:0] exp_s;
    wire phase_c_s;
    wire phase_d_s;
    wire arm_inhibit_s;
    wire slow_trig_s;
    wire slow_clk_s;
    wire lo_en_n_s;
    wire hi_en_n_s;
    wire clear_s;
    wire load_s;

    twdl_sync2 #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i ({data_i, expander_recognized_n_i, phase_c_i, phase_d_i,
                   arm_inhibit_i, slow_module_triggered_i, slow_module_clock_i,
                   ~diff_low_byte_enable_n_i, ~diff_high_byte_enable_n_i,
                   trigger_clear_i, delay_load_enable_i}),
        .sync_o  (sync_in)
    );

    assign data_s        = sync_in[SYNC_W-1 -: `TWDL_WORD_BITS];
    assign exp_s         = sync_in[9 +: `TWDL_EXP_INPUTS];
    assign phase_c_s     = sync_in[8];
    assign phase_d_s     = sync_in[7];
    assign arm_inhibit_s = sync_in[6];
    assign slow_trig_s   = sync_in[5];
    assign slow_clk_s    = sync_in[4];
    assign lo_en_n_s     = ~sync_in[3];
    assign hi_en_n_s     = ~sync_in[2];
    assign clear_s       = sync_in[1];
    assign load_s        = sync_in[0];

    // Edge detectors read only synchronised copies
    reg phase_c_q;
    reg phase_d_q;
    reg slow_clk_q;
    wire phase_c_rise  = phase_c_s & ~phase_c_q;
    wire phase_d_rise  = phase_d_s & ~phase_d_q;
    wire slow_clk_rise = slow_clk_s & ~slow_clk_q;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_c_q  <= 1'b0;
            phase_d_q  <= 1'b0;
            slow_clk_q <= 1'b0;
        end else begin
            phase_c_q  <= phase_c_s;
            phase_d_q  <= phase_d_s;
            slow_clk_q <= slow_clk_s;
        end
    end

    // Word recognizer; the fifth input is tied inactive (low) on the master
    wire recognized_n;

    twdl_word_match u_match (
        .clk_i           (clk_i),
        .rst_n_i         (rst_n_i),
        .data_i          (data_s),
        .polarity_i      (bit_polarity_select_i),
        .dont_care_i     (bit_dont_care_i),
        .extra_match_n_i (1'b0),
        .recognized_n_o  (recognized_n)
    );

    // Recognizer latch holds the result while expander signals settle
    reg recog_latch_n;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            recog_latch_n <= 1'b1;
        end else if (phase_c_rise) begin
            recog_latch_n <= recognized_n;
        end
    end

    // Unused expander inputs must be strapped low outside
    wire combined_recognition = ~(recog_latch_n | (|exp_s));

    // Slow-arms mode keeps the latch masked until the slow card fires
    wire latch_masked = arm_inhibit_s | (slow_arms_fast_mode_i & ~slow_trig_s);

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            triggered_o               <= 1'b0;
            fast_module_triggered_n_o <= 1'b1;
        end else if (clear_s) begin
            triggered_o               <= 1'b0;
            fast_module_triggered_n_o <= 1'b1;
        end else if (phase_d_rise && !latch_masked && combined_recognition) begin
            triggered_o               <= 1'b1;
            fast_module_triggered_n_o <= 1'b0;
        end
    end

    // Divide-by-four network: preset on load, runs only once triggered
    reg [1:0] div;
    wire      quarter_tick = triggered_o && (div == 2'b00);

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div <= `TWDL_DIV_PRESET;
        end else if (load_s) begin
            div <= `TWDL_DIV_PRESET;
        end else if (triggered_o) begin
            div <= div - 2'b01;
        end
    end

    // Cascaded delay counter, loaded with the complemented quarter delay
    // 16 bits at quarter rate cover 262,140 clocks, well past 32,700
    reg [`TWDL_LOWER_BITS-1:0] lower;
    reg [`TWDL_UPPER_BITS-1:0] upper;
    reg                        lower_msb_q;
    wire lower_msb        = lower[`TWDL_LOWER_BITS-1];
    wire upper_carry_n    = ~(&upper);
    wire lower_terminal   = (lower == `TWDL_LOWER_TERMINAL);
    wire next_halt        = ~upper_carry_n & lower_terminal;
    wire count_enable     = quarter_tick & ~acquisition_halt_request_o;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lower       <= {`TWDL_LOWER_BITS{1'b0}};
            upper       <= {`TWDL_UPPER_BITS{1'b0}};
            lower_msb_q <= 1'b0;
        end else if (load_s) begin
            lower       <= delay_load_nibble_bus_i;
            upper       <= delay_load_upper_i;
            lower_msb_q <= delay_load_nibble_bus_i[`TWDL_LOWER_BITS-1];
        end else begin
            lower_msb_q <= lower_msb;
            if (count_enable) begin
                lower <= lower + 4'h1;
            end
            // Upper advances on the falling msb, i.e. lower wrap carry
            if (lower_msb_q && !lower_msb) begin
                upper <= upper + 12'h001;
            end
        end
    end

    // Halt request and the three-clock run-out of acquisition
    reg [`TWDL_HALT_CNT_BITS-1:0] halt_cnt;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acquisition_halt_request_o <= 1'b0;
            acquisition_running_o      <= 1'b0;
            halt_cnt                   <= 2'h0;
        end else if (clear_s || load_s) begin
            acquisition_halt_request_o <= 1'b0;
            acquisition_running_o      <= 1'b1;
            halt_cnt                   <= 2'h0;
        end else begin
            if (triggered_o && next_halt) begin
                acquisition_halt_request_o <= 1'b1;
            end
            if (acquisition_halt_request_o && acquisition_running_o) begin
                if (halt_cnt == `TWDL_HALT_CLOCKS - 1) begin
                    acquisition_running_o <= 1'b0;
                end else begin
                    halt_cnt <= halt_cnt + 2'h1;
                end
            end
        end
    end

    // Difference counter on slow-module clock edges
    wire diff_count_enable = slow_trig_s & fast_module_triggered_n_o;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            diff_count_o <= 16'h0000;
        end else if (clear_s) begin
            diff_count_o <= 16'h0000;
        end else if (slow_clk_rise && diff_count_enable &&
                     diff_count_o != `TWDL_DIFF_MAX) begin
            diff_count_o <= diff_count_o + 16'h0001;
        end
    end

    // Readback bus; low enable wins if both are asserted
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_data_o    <= 8'h00;
            bus_data_oe_o <= 1'b0;
        end else if (!lo_en_n_s) begin
            bus_data_o    <= diff_count_o[7:0];
            bus_data_oe_o <= 1'b1;
        end else if (!hi_en_n_s) begin
            bus_data_o    <= diff_count_o[15:8];
            bus_data_oe_o <= 1'b1;
        end else begin
            bus_data_o    <= 8'h00;
            bus_data_oe_o <= 1'b0;
        end
    end
endmodule

// ---- bench/twdl_monitor.sv ----
// Port checker for the trigger, delay and difference counter block
`timescale 1ns/10ps
module twdl_monitor (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        trigger_clear_i,
    input wire logic        slow_module_triggered_i,
    input wire logic        diff_low_byte_enable_n_i,
    input wire logic        diff_high_byte_enable_n_i,
    input wire logic        triggered_o,
    input wire logic        fast_module_triggered_n_o,
    input wire logic        acquisition_halt_request_o,
    input wire logic        acquisition_running_o,
    input wire logic [7:0]  bus_data_o,
    input wire logic        bus_data_oe_o,
    input wire logic [15:0] diff_count_o
);
    // Short history windows absorb the synchroniser lag on the inputs
    logic [7:0] clr_h;
    logic [7:0] slow_h;
    logic [7:0] rd_h;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clr_h  <= 8'h00;
            slow_h <= 8'h00;
            rd_h   <= 8'h00;
        end else begin
            clr_h  <= {clr_h[6:0], trigger_clear_i};
            slow_h <= {slow_h[6:0], slow_module_triggered_i};
            rd_h   <= {rd_h[6:0], !(diff_low_byte_enable_n_i && diff_high_byte_enable_n_i)};
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_trig_inverse: assert property (fast_module_triggered_n_o == !triggered_o)
        else $error("trigger outputs disagree");
    chk_trig_sticky: assert property ($fell(triggered_o) |-> |clr_h)
        else $error("trigger dropped without clear");
    chk_halt_needs_trig: assert property ($rose(acquisition_halt_request_o) |-> triggered_o)
        else $error("halt before trigger");
    chk_halt_stops: assert property ($rose(acquisition_halt_request_o) |-> ##3 !acquisition_running_o)
        else $error("acquisition not stopped three clocks after halt");
    chk_halt_runout: assert property ($rose(acquisition_halt_request_o) |-> ##2 acquisition_running_o)
        else $error("acquisition stopped early after halt");
    chk_diff_limit: assert property (diff_count_o <= 16'h7fff)
        else $error("difference count past limit");
    chk_diff_step: assert property ($changed(diff_count_o) |->
        diff_count_o == $past(diff_count_o) + 16'h1 || (diff_count_o == 16'h0 && |clr_h))
        else $error("difference count jumped");
    chk_diff_slow_first: assert property ($changed(diff_count_o) && diff_count_o != 16'h0 |-> |slow_h)
        else $error("difference counted without slow trigger");
    chk_diff_frozen: assert property (triggered_o && $past(triggered_o, 4) && !(|clr_h) |=> $stable(diff_count_o))
        else $error("difference count moved after trigger");
    chk_bus_idle: assert property (!bus_data_oe_o |-> bus_data_o == 8'h00)
        else $error("bus data while released");
    chk_bus_cause: assert property (bus_data_oe_o |-> |rd_h)
        else $error("bus driven without byte enable");
    cover property ($rose(triggered_o));
    cover property ($rose(acquisition_halt_request_o));
    cover property ($fell(acquisition_running_o));
    cover property ($rose(bus_data_oe_o) && diff_count_o != 16'h0);
endmodule
bind twdl_trigger_delay twdl_monitor twdl_monitor_i (
    .clk_i, .rst_n_i, .trigger_clear_i, .slow_module_triggered_i, .diff_low_byte_enable_n_i,
    .diff_high_byte_enable_n_i, .triggered_o, .fast_module_triggered_n_o,
    .acquisition_halt_request_o, .acquisition_running_o, .bus_data_o, .bus_data_oe_o,
    .diff_count_o
);

// ---- bench/twdl_far_side.sv ----
// Far side model: acquisition clock phases and a slow card that triggers, then clocks
`timescale 1ns/10ps
module twdl_far_side #(
    parameter PULSES = 5
) (
    input  wire logic clk_i,
    input  wire logic start_i,
    output logic      phase_c_o,
    output logic      phase_d_o,
    output logic      slow_trig_o,
    output logic      slow_clk_o
);
    logic [2:0] ph;
    int         n;
    initial begin
        ph = 3'h0;
        n = 0;
        {phase_c_o, phase_d_o, slow_trig_o, slow_clk_o} = 4'h0;
    end
    always @(posedge clk_i) begin
        ph          <= ph + 3'h1;
        // Phase D lags C so the recognition latch settles before the trigger latch samples
        phase_c_o   <= ph < 3'h4;
        phase_d_o   <= ph >= 3'h2 && ph < 3'h6;
        slow_trig_o <= start_i;
        n           <= start_i ? (n < 4 * PULSES + 4 ? n + 1 : n) : 0;
        // Slow clock stands low outside its burst
        slow_clk_o  <= start_i && n >= 4 && n < 4 * PULSES + 4 && n[1];
    end
endmodule

// ---- bench/testbench.sv ----
// Self-checking testbench for the trigger, delay and difference counter block
`timescale 1ns/10ps
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  data = 4'h0, pol = 4'hf, dc = 4'h0, exn = 4'h0, lower = 4'h0;
    logic        inh = 1'b0, mode = 1'b0, clr = 1'b0, ld = 1'b0, start = 1'b0;
    logic        lo_n = 1'b1, hi_n = 1'b1;
    logic [11:0] upper = 12'h0;
    logic        ph_c, ph_d, s_trig, s_clk, trig, trig_n, halt, run, oe;
    logic [7:0]  bus;
    logic [15:0] diff;
    int          errors = 0, checks = 0;
    // data, polarity, don't care, expander, inhibit, expected trigger
    logic [17:0] tbl [6] = '{{4'ha, 4'ha, 4'h0, 4'h0, 1'b0, 1'b1},
        {4'ha, 4'h5, 4'h0, 4'h0, 1'b0, 1'b0}, {4'ha, 4'h5, 4'hf, 4'h0, 1'b0, 1'b1},
        {4'h3, 4'h2, 4'he, 4'h0, 1'b0, 1'b0}, {4'h6, 4'h6, 4'h0, 4'h4, 1'b0, 1'b0},
        {4'h6, 4'h6, 4'h0, 4'h0, 1'b1, 1'b0}};
    always #2.5 clk_i = ~clk_i;
    twdl_far_side twdl_far_side_i (.clk_i(clk_i), .start_i(start), .phase_c_o(ph_c),
        .phase_d_o(ph_d), .slow_trig_o(s_trig), .slow_clk_o(s_clk));
    twdl_trigger_delay twdl_trigger_delay_i (.clk_i(clk_i), .rst_n_i(rst_n), .phase_c_i(ph_c),
        .phase_d_i(ph_d), .data_i(data), .bit_polarity_select_i(pol), .bit_dont_care_i(dc),
        .expander_recognized_n_i(exn), .arm_inhibit_i(inh), .slow_arms_fast_mode_i(mode),
        .trigger_clear_i(clr), .delay_load_enable_i(ld), .delay_load_nibble_bus_i(lower),
        .delay_load_upper_i(upper), .slow_module_triggered_i(s_trig),
        .slow_module_clock_i(s_clk), .diff_low_byte_enable_n_i(lo_n),
        .diff_high_byte_enable_n_i(hi_n), .triggered_o(trig), .fast_module_triggered_n_o(trig_n),
        .acquisition_halt_request_o(halt), .acquisition_running_o(run), .bus_data_o(bus),
        .bus_data_oe_o(oe), .diff_count_o(diff));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wait_for(input int sel, input int lim);
        int k;
        for (k = 0; k < lim && (sel == 0 ? trig : sel == 1 ? halt : oe) !== 1'b1; k++)
            @(negedge clk_i);
        if (k == lim) begin
            errors++;
            wrap_up();
        end
    endtask
    // Load, then clear, then arm with a word that cannot match
    task automatic prep(input logic [11:0] up, input logic [3:0] lo, input logic m);
        {upper, lower, mode, data, pol, dc} = {up, lo, m, 4'h0, 4'hf, 4'h0};
        ld = 1'b1;
        cyc(4);
        ld = 1'b0;
        clr = 1'b1;
        cyc(4);
        clr = 1'b0;
        cyc(4);
    endtask
    task automatic rd(input logic hi, input logic [7:0] exp);
        {lo_n, hi_n} = {hi, !hi};
        wait_for(2, 10);
        cmp({8'h0, bus}, {8'h0, exp});
        {lo_n, hi_n} = 2'b11;
        cyc(6);
    endtask
    // Load value is the complement of the quarter-rate step count
    task automatic delay_run(input logic [11:0] up, input logic [3:0] lo);
        int steps;
        steps = 16'hffff - {up, lo};
        prep(up, lo, 1'b0);
        {data, pol} = 8'h55;
        wait_for(0, 40);
        data = 4'h0;
        cyc(4 * steps - 6);
        cmp({15'h0, halt}, 16'h0);
        wait_for(1, 16);
        cmp({15'h0, trig}, 16'h1);
        cyc(2);
        cmp({15'h0, run}, 16'h1);
        cyc(1);
        cmp({15'h0, run}, 16'h0);
    endtask
    initial begin
        cyc(3);
        rst_n = 1'b1;
        cyc(2);
        cmp({14'h0, trig_n, oe}, 16'h2);
        foreach (tbl[i]) begin
            prep(12'hfff, 4'h0, 1'b0);
            {data, pol, dc, exn, inh} = tbl[i][17:1];
            cyc(40);
            cmp({15'h0, trig}, {15'h0, tbl[i][0]});
            {inh, exn} = 5'h00;
        end
        delay_run(12'hfff, 4'hc);
        delay_run(12'hffe, 4'hd);
        delay_run(12'hdff, 4'h7);
        rd(1'b0, 8'h00);
        prep(12'hfff, 4'h0, 1'b1);
        {data, pol} = 8'h55;
        cyc(40);
        cmp({15'h0, trig}, 16'h0);
        data = 4'h0;
        cyc(20);
        start = 1'b1;
        cyc(40);
        data = 4'h5;
        wait_for(0, 40);
        cyc(20);
        cmp(diff, 16'h0005);
        rd(1'b0, 8'h05);
        rd(1'b1, 8'h00);
        clr = 1'b1;
        start = 1'b0;
        cyc(4);
        clr = 1'b0;
        cyc(4);
        rd(1'b0, 8'h00);
        wrap_up();
    end
endmodule
